// file: rtl/pwr_mode_pkg.sv
package pwr_mode_pkg;

   // register byte offsets on the axi4-lite slave
   localparam logic [7:0]  MISC_CTRL1_OFFS   = 8'h00;
   localparam logic [7:0]  CLK_CTRL_OFFS     = 8'h04;
   localparam logic [7:0]  MODE_STATUS_OFFS  = 8'h08;

   // misc_control_reg1 field positions
   localparam int          SLOW_SEL_BIT      = 0;
   localparam int          SLOW_DIV_LSB      = 1;
   // clock_ctrl_status_reg field positions
   localparam int          OSC_IE_BIT        = 0;

   // reset values
   localparam logic [2:0]  MISC_CTRL1_RST    = 3'h0;
   localparam logic        OSC_IE_RST        = 1'b0;

   // priority bit encodings of the condition code register
   localparam logic [1:0]  PRIO_LEVEL0       = 2'h2;
   localparam logic [1:0]  PRIO_LEVEL1       = 2'h1;
   localparam logic [1:0]  PRIO_LEVEL2       = 2'h0;
   localparam logic [1:0]  PRIO_LEVEL3       = 2'h3;

   localparam logic [7:0]  HALT_OPCODE       = 8'h8E;

   // division ratios, as log2 of the ratio
   localparam logic [2:0]  RUN_DIV_LOG2      = 3'h1;
   localparam logic [2:0]  SLOW_DIV_BASE_LOG2 = 3'h2;

   // oscillator stabilisation delay in oscillator (core_clk_in) cycles
   localparam int          OSC_STAB_CYCLES   = 4096;

   // axi response codes
   localparam logic [1:0]  AXI_OKAY          = 2'h0;
   localparam logic [1:0]  AXI_SLVERR        = 2'h2;

   typedef enum logic [2:0] {
      MODE_RUN         = 3'b000,
      MODE_SLOW        = 3'b001,
      MODE_WAIT        = 3'b010,
      MODE_SLOW_WAIT   = 3'b011,
      MODE_ACTIVE_HALT = 3'b100,
      MODE_HALT        = 3'b101,
      MODE_OSC_STAB    = 3'b110
   } pwr_mode_t;

endpackage

// file: rtl/clk_divider.sv
`timescale 1ns/1ps
// divides the oscillator by 2^div_log2, emitting a one-cycle tick per period
module clk_divider #(
   parameter int W = 5
) (
   input  wire logic         core_clk_in,
   input  wire logic         arst_n_in,
   input  wire logic [2:0]   div_log2_in,
   output logic              tick_out
);
   if (W < 5) begin : g_w_chk
      $error("clk_divider needs at least 5 bits for divide by 32");
   end

   logic [W-1:0] cnt;
   logic [W-1:0] mask;

   // mask selects the low bits that must all be ones at end of a period
   always_comb begin
      mask = W'((1 << div_log2_in) - 1);
   end

   // free-running counter; a ratio change takes effect at once through the combinational mask
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + W'(1);
      end
   end

   assign tick_out = ((cnt & mask) == mask);
endmodule // clk_divider

// file: rtl/power_mode_controller.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Contract
// R1: reset starts run mode, oscillator over two
// R2: slow enable bit plus two-bit select field
// R3: slow mode divides by 4 to 32
// R4: select 00..11 maps to 4,8,16,32
// R5: wait during slow enters slow-wait
// R6: wait stops cpu clock, peripherals run
// R7: wait entry forces priority bits to 10
// R8: any interrupt or reset leaves wait
// R9: stack push sets level, pop restores
// R10: halt picks active-halt when osc enable
// R11: active-halt keeps only oscillator and timebase
// R12: active-halt exits on timebase, wake, reset
// R13: interrupt exit from active-halt skips delay
// R14: halt entry forces 10, pending wakes
// R15: active-halt with watchdog gives no reset
// R16: halt stops oscillator and all peripherals
// R17: halt exit waits 4096 cycles
// R18: option bit decides watchdog reset on halt
// R19: opcode 8E is the halt instruction
// R20: software clears pending flags before halt
// R21: priority encoding 10,01,00,11 for levels
module power_mode_controller
   import pwr_mode_pkg::*;
#(
   parameter int STAB_CYCLES = pwr_mode_pkg::OSC_STAB_CYCLES
) (
   input  wire logic         core_clk_in,
   input  wire logic         arst_n_in,
   // axi4-lite slave
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   // cpu side
   input  wire logic         instr_valid_in,
   input  wire logic [7:0]   instr_opcode_in,
   input  wire logic         wait_for_interrupt_instr_in,
   input  wire logic         irq_pending_in,
   input  wire logic         wake_irq_in,
   input  wire logic         rtc_irq_in,
   input  wire logic         irq_enter_in,
   input  wire logic [1:0]   irq_level_in,
   input  wire logic         irq_return_in,
   input  wire logic         watchdog_enabled_in,
   input  wire logic         watchdog_halt_option_in,
   output logic              cpu_clk_en_out,
   output logic              periph_clk_en_out,
   output logic              rtc_clk_en_out,
   output logic              osc_enable_out,
   output logic              cpu_run_out,
   output logic              prio_force_out,
   output logic [1:0]        prio_bits_out,
   output logic              watchdog_reset_out,
   output logic [2:0]        mode_out
);
   // the settle counter is sixteen bits wide
   if (STAB_CYCLES < 1 || STAB_CYCLES > 65535) begin : g_stab_chk
      $error("STAB_CYCLES out of range");
   end

   pwr_mode_t  mode;
   pwr_mode_t  next_mode;
   logic       slow_mode_select;
   logic [1:0] slow_clock_divider_select;
   logic       osc_interrupt_enable;
   logic [15:0] stab_cnt;
   logic [1:0] prio_bits;
   logic [1:0] prio_stack;
   logic       prio_force;
   logic       wdg_reset;
   logic [2:0] div_log2;
   logic       div_tick;
   logic       halt_exec;
   logic       wfi_exec;
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic       do_write;

   // decode used for the halt decision
   function automatic logic is_halt(input logic [7:0] op);
      return op == HALT_OPCODE; // R19
   endfunction

   // run and slow are the only modes in which the cpu executes
   function automatic logic is_awake(input pwr_mode_t m);
      return m == MODE_RUN || m == MODE_SLOW;
   endfunction

   // modes whose entry forces the priority bits to level 0
   function automatic logic is_sleep(input pwr_mode_t m);
      return m == MODE_WAIT || m == MODE_SLOW_WAIT || m == MODE_ACTIVE_HALT || m == MODE_HALT;
   endfunction

   // instructions only count while the cpu is executing
   assign halt_exec = instr_valid_in && is_halt(instr_opcode_in) &&
                      is_awake(mode); // R19
   assign wfi_exec  = wait_for_interrupt_instr_in &&
                      is_awake(mode);

   // ---------------- axi4-lite write path ----------------
   // address and data are latched independently so either may come first
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr[7:2] == MISC_CTRL1_OFFS[7:2] ||
                          aw_addr[7:2] == CLK_CTRL_OFFS[7:2] ||
                          aw_addr[7:2] == MODE_STATUS_OFFS[7:2]) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // slow mode control bits, only byte lane 0 carries them
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         slow_mode_select          <= MISC_CTRL1_RST[SLOW_SEL_BIT]; // R2
         slow_clock_divider_select <= MISC_CTRL1_RST[SLOW_DIV_LSB +: 2];
      end else if (do_write && w_strb[0] && aw_addr[7:2] == MISC_CTRL1_OFFS[7:2]) begin
         slow_mode_select          <= w_data[SLOW_SEL_BIT]; // R2
         slow_clock_divider_select <= w_data[SLOW_DIV_LSB +: 2]; // R2
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_interrupt_enable <= OSC_IE_RST;
      end else if (do_write && w_strb[0] && aw_addr[7:2] == CLK_CTRL_OFFS[7:2]) begin
         osc_interrupt_enable <= w_data[OSC_IE_BIT];
      end
   end

   // ---------------- axi4-lite read path ----------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= AXI_OKAY;
         case (s_axi_araddr[7:2])
            MISC_CTRL1_OFFS[7:2]:
               s_axi_rdata <= {29'h0, slow_clock_divider_select, slow_mode_select};
            CLK_CTRL_OFFS[7:2]:
               s_axi_rdata <= {31'h0, osc_interrupt_enable};
            MODE_STATUS_OFFS[7:2]:
               s_axi_rdata <= {27'h0, prio_bits, mode};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- mode sequencing ----------------
   always_comb begin
      next_mode = mode;
      case (mode)
         MODE_RUN, MODE_SLOW: begin
            if (halt_exec && osc_interrupt_enable) begin
               next_mode = irq_pending_in ? mode : MODE_ACTIVE_HALT; // R10 R14
            end else if (halt_exec) begin
               // pending interrupt aborts entry; watchdog reset goes via reset
               next_mode = irq_pending_in ? mode : MODE_HALT; // R10 R14
            end else if (wfi_exec) begin
               next_mode = slow_mode_select ? MODE_SLOW_WAIT : MODE_WAIT; // R5 R6
            end else begin
               next_mode = slow_mode_select ? MODE_SLOW : MODE_RUN; // R2
            end
         end
         MODE_WAIT, MODE_SLOW_WAIT: begin
            if (irq_pending_in) begin
               next_mode = slow_mode_select ? MODE_SLOW : MODE_RUN; // R8
            end
         end
         MODE_ACTIVE_HALT: begin
            // interrupt exit resumes at once, no stabilisation wait
            if (rtc_irq_in || wake_irq_in) begin
               next_mode = slow_mode_select ? MODE_SLOW : MODE_RUN; // R12 R13
            end
         end
         MODE_HALT: begin
            if (wake_irq_in) begin
               next_mode = MODE_OSC_STAB; // R17
            end
         end
         MODE_OSC_STAB: begin
            if (stab_cnt == 16'(STAB_CYCLES - 1)) begin
               next_mode = slow_mode_select ? MODE_SLOW : MODE_RUN; // R17
            end
         end
         default: next_mode = MODE_RUN;
      endcase
   end

   // reset from any mode lands in run; the reset vector fetch is the cpu's job
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mode <= MODE_RUN; // R1
      end else begin
         mode <= next_mode;
      end
   end

   // settle counter runs on every oscillator clock; scale the parameter to suit
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stab_cnt <= 16'h0000;
      end else if (mode != MODE_OSC_STAB) begin
         stab_cnt <= 16'h0000;
      end else begin
         stab_cnt <= stab_cnt + 16'h0001; // R17
      end
   end

   // ---------------- priority bits of condition code register ----------------
   // mirrors the cpu's bits; force pulses tell the cpu to load prio_bits_out
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prio_bits  <= PRIO_LEVEL3; // R21
         prio_stack <= PRIO_LEVEL3;
         prio_force <= 1'b0;
      end else begin
         prio_force <= 1'b0;
         if (next_mode != mode && is_sleep(next_mode)) begin
            prio_bits  <= PRIO_LEVEL0; // R7 R14 R21
            prio_force <= 1'b1;
         end else if (irq_enter_in) begin
            prio_stack <= prio_bits; // R9
            prio_bits  <= irq_level_in; // R9
            prio_force <= 1'b1;
         end else if (irq_return_in) begin
            prio_bits  <= prio_stack; // R9
            prio_force <= 1'b1;
         end
      end
   end

   // ---------------- watchdog interaction ----------------
   // only a halt with the oscillator interrupt off may trip the watchdog, even one a pending interrupt aborts; active-halt never does
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wdg_reset <= 1'b0;
      end else begin
         wdg_reset <= halt_exec && !osc_interrupt_enable && watchdog_enabled_in &&
                      !watchdog_halt_option_in; // R15 R18
      end
   end

   // ---------------- clock generation ----------------
   always_comb begin
      div_log2 = slow_mode_select ?
                 3'(SLOW_DIV_BASE_LOG2 + {1'b0, slow_clock_divider_select}) : // R3 R4
                 RUN_DIV_LOG2; // R1
   end

   clk_divider #(
      .W (5)
   ) clk_divider_inst (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .div_log2_in (div_log2),
      .tick_out    (div_tick)
   );

   // clock enables per domain, registered to stay glitch free
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cpu_clk_en_out    <= 1'b0;
         periph_clk_en_out <= 1'b0;
         rtc_clk_en_out    <= 1'b0;
         osc_enable_out    <= 1'b1;
      end else begin
         cpu_clk_en_out    <= div_tick && is_awake(mode); // R6
         periph_clk_en_out <= div_tick && (is_awake(mode) ||
                              mode == MODE_WAIT || mode == MODE_SLOW_WAIT); // R5 R11 R16
         rtc_clk_en_out    <= div_tick && (mode != MODE_HALT && mode != MODE_OSC_STAB); // R11
         osc_enable_out    <= (next_mode != MODE_HALT); // R16
      end
   end

   // status outputs straight from the mode, priority and watchdog registers
   assign cpu_run_out        = is_awake(mode);
   assign prio_force_out     = prio_force;
   assign prio_bits_out      = prio_bits;
   assign watchdog_reset_out = wdg_reset;
   assign mode_out           = mode;
endmodule // power_mode_controller

// file: test/pmc_checker.sv
`timescale 1ns/1ps
// watches the mode sequencing at the top-level pins
module pmc_checker
   import pwr_mode_pkg::*;
#(
   parameter int STAB_CYCLES = OSC_STAB_CYCLES
) (
   input wire logic       core_clk_in,
   input wire logic       arst_n_in,
   input wire logic       instr_valid_in,
   input wire logic [7:0] instr_opcode_in,
   input wire logic       wait_for_interrupt_instr_in,
   input wire logic       irq_pending_in,
   input wire logic       wake_irq_in,
   input wire logic       rtc_irq_in,
   input wire logic       watchdog_enabled_in,
   input wire logic       watchdog_halt_option_in,
   input wire logic       cpu_clk_en_out,
   input wire logic       periph_clk_en_out,
   input wire logic       rtc_clk_en_out,
   input wire logic       osc_enable_out,
   input wire logic       cpu_run_out,
   input wire logic       prio_force_out,
   input wire logic [1:0] prio_bits_out,
   input wire logic       watchdog_reset_out,
   input wire logic [2:0] mode_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   int   stab_cnt;
   logic awake;
   assign awake = (mode_out == MODE_RUN) || (mode_out == MODE_SLOW);
   // cycles spent settling, compared against the parameter on exit
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) stab_cnt <= 0;
      else if (mode_out == MODE_OSC_STAB) stab_cnt <= stab_cnt + 1;
      else stab_cnt <= 0;
   end
   sequence s_halt_cmd;
      instr_valid_in && instr_opcode_in == HALT_OPCODE && awake && !irq_pending_in;
   endsequence
   sequence s_sleep_entry;
      $past(awake) && !awake;
   endsequence
   property p_halt_entry;
      s_halt_cmd |=> mode_out inside {MODE_ACTIVE_HALT, MODE_HALT};
   endproperty
   a_halt_entry: assert property (p_halt_entry) else $error("halt opcode ignored");
   property p_wfi;
      wait_for_interrupt_instr_in && awake && !irq_pending_in |=>
         mode_out == (($past(mode_out) == MODE_SLOW) ? MODE_SLOW_WAIT : MODE_WAIT);
   endproperty
   a_wfi: assert property (p_wfi) else $error("wait entry wrong");
   property p_prio_force;
      s_sleep_entry |-> ##[0:1] (prio_force_out && prio_bits_out == PRIO_LEVEL0);
   endproperty
   a_prio_force: assert property (p_prio_force) else $error("priority not forced");
   property p_cpu_stop;
      !awake && $past(mode_out) == mode_out |-> !cpu_clk_en_out && !cpu_run_out;
   endproperty
   a_cpu_stop: assert property (p_cpu_stop) else $error("cpu clocked asleep");
   property p_ah_clocks;
      mode_out == MODE_ACTIVE_HALT && $past(mode_out) == MODE_ACTIVE_HALT |->
         osc_enable_out && !periph_clk_en_out && !watchdog_reset_out;
   endproperty
   a_ah_clocks: assert property (p_ah_clocks) else $error("active-halt clocks");
   property p_ah_wdg;
      s_halt_cmd ##1 mode_out == MODE_ACTIVE_HALT |-> !watchdog_reset_out;
   endproperty
   a_ah_wdg: assert property (p_ah_wdg) else $error("watchdog reset in active-halt");
   property p_halt_off;
      mode_out == MODE_HALT && $past(mode_out) == MODE_HALT |->
         !osc_enable_out && !periph_clk_en_out && !rtc_clk_en_out;
   endproperty
   a_halt_off: assert property (p_halt_off) else $error("halt left clocks on");
   property p_ah_exit;
      mode_out == MODE_ACTIVE_HALT && (rtc_irq_in || wake_irq_in) |=> awake;
   endproperty
   a_ah_exit: assert property (p_ah_exit) else $error("active-halt exit slow");
   property p_halt_exit;
      mode_out == MODE_HALT && wake_irq_in |=> mode_out == MODE_OSC_STAB;
   endproperty
   a_halt_exit: assert property (p_halt_exit) else $error("halt exit no settle");
   property p_stab_len;
      $past(mode_out) == MODE_OSC_STAB && mode_out != MODE_OSC_STAB |->
         stab_cnt == STAB_CYCLES;
   endproperty
   a_stab_len: assert property (p_stab_len) else $error("settle length wrong");
   property p_wdg;
      s_halt_cmd ##0 (watchdog_enabled_in && !watchdog_halt_option_in)
         ##1 mode_out == MODE_HALT |-> ##[0:1] watchdog_reset_out;
   endproperty
   a_wdg: assert property (p_wdg) else $error("no watchdog reset");
endmodule // pmc_checker

bind power_mode_controller pmc_checker #(.STAB_CYCLES(STAB_CYCLES)) pmc_checker_inst (
   .core_clk_in, .arst_n_in, .instr_valid_in, .instr_opcode_in,
   .wait_for_interrupt_instr_in, .irq_pending_in, .wake_irq_in, .rtc_irq_in,
   .watchdog_enabled_in, .watchdog_halt_option_in, .cpu_clk_en_out, .periph_clk_en_out,
   .rtc_clk_en_out, .osc_enable_out, .cpu_run_out, .prio_force_out, .prio_bits_out,
   .watchdog_reset_out, .mode_out);

// file: test/irq_model.sv
`timescale 1ns/1ps
// interrupt logic and cpu stand-in: latches requests, services them once the cpu runs
module irq_model
   import pwr_mode_pkg::*;
(
   input  wire logic       core_clk_in,
   input  wire logic       arst_n_in,
   input  wire logic [2:0] set_req_in,
   input  wire logic       cpu_run_in,
   output logic            irq_pending_out,
   output logic            wake_irq_out,
   output logic            rtc_irq_out,
   output logic            irq_enter_out,
   output logic [1:0]      irq_level_out
);
   logic [2:0] req;
   // bit0 plain source, bit1 wake-capable line, bit2 timebase
   assign irq_pending_out = |req;
   assign wake_irq_out    = req[1];
   assign rtc_irq_out     = req[2];
   assign irq_level_out   = PRIO_LEVEL1;
   // vector fetch clears the latches, so one wake runs one routine
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         req <= 3'h0;
         irq_enter_out <= 1'b0;
      end else begin
         irq_enter_out <= cpu_run_in && (|req);
         req <= (cpu_run_in && (|req)) ? 3'h0 : (req | set_req_in);
      end
   end
endmodule // irq_model

// file: test/power_mode_controller_test.sv
`timescale 1ns/1ps
module power_mode_controller_test;
   import pwr_mode_pkg::*;
   localparam int STAB = 8;
   logic core_clk_in = 1'b0, arst_n_in = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, instr_opcode_in = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [2:0] set_req = 3'h0, mode_out;
   logic [1:0] s_axi_bresp, s_axi_rresp, irq_level_in, prio_bits_out;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, instr_valid_in = 0, wait_for_interrupt_instr_in = 0;
   logic irq_return_in = 0, watchdog_enabled_in = 0, watchdog_halt_option_in = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic irq_pending_in, wake_irq_in, rtc_irq_in, irq_enter_in, cpu_clk_en_out;
   logic periph_clk_en_out, rtc_clk_en_out, osc_enable_out, cpu_run_out;
   logic prio_force_out, watchdog_reset_out;
   int err_total = 0, n_tests = 0, n, i;
   always #5 core_clk_in = ~core_clk_in;
   power_mode_controller #(.STAB_CYCLES(STAB)) power_mode_controller_inst (.*);
   irq_model irq_model_inst (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
      .set_req_in(set_req), .cpu_run_in(cpu_run_out), .irq_pending_out(irq_pending_in),
      .wake_irq_out(wake_irq_in), .rtc_irq_out(rtc_irq_in), .irq_enter_out(irq_enter_in),
      .irq_level_out(irq_level_in));
   task automatic test_done;
      $display("counts: %0d checks, %0d mismatches", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a bound ran out: count it and close the run
   task automatic hang;
      err_total++;
      $display("ERROR %0t: wait ran out", $time);
      test_done;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge core_clk_in);
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int t;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (t = 0; t < 40; t++) begin
         @(posedge core_clk_in);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (t == 40) hang;
      s_axi_bready <= 1'b0;
      cmp(s_axi_bresp, r);
      @(posedge core_clk_in); // bready stays low for one edge
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (t = 0; t < 40; t++) begin
         @(posedge core_clk_in);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (t == 40) hang;
      s_axi_rready <= 1'b0;
      cmp(s_axi_rdata, d);
      cmp(s_axi_rresp, r);
      @(posedge core_clk_in); // rready stays low for one edge
   endtask
   // one-cycle instruction strobe; callers let an edge pass before the next
   task automatic op(input logic w, input logic [7:0] c);
      instr_opcode_in <= c;
      if (w) wait_for_interrupt_instr_in <= 1'b1;
      else instr_valid_in <= 1'b1;
      @(posedge core_clk_in);
      wait_for_interrupt_instr_in <= 1'b0;
      instr_valid_in <= 1'b0;
   endtask
   task automatic irq(input logic [2:0] v);
      set_req <= v;
      @(posedge core_clk_in);
      set_req <= 3'h0;
   endtask
   task automatic wait_mode(input pwr_mode_t m);
      int t;
      for (t = 0; t < 200 && mode_out !== m; t++) @(posedge core_clk_in);
      if (t == 200) hang;
   endtask
   // tick-to-tick distance of the cpu or peripheral enable
   task automatic period(input logic p, output int c);
      int t;
      for (t = 0; t < 100 && (p ? periph_clk_en_out : cpu_clk_en_out) !== 1'b1; t++)
         @(posedge core_clk_in);
      c = 0;
      do begin
         @(posedge core_clk_in);
         c++;
      end while ((p ? periph_clk_en_out : cpu_clk_en_out) !== 1'b1 && c < 100);
      if (t == 100 || c == 100) hang;
   endtask
   initial begin
      tick(12);
      arst_n_in <= 1'b1;
      tick(1);
      rd(MISC_CTRL1_OFFS, 32'h0, AXI_OKAY);
      rd(CLK_CTRL_OFFS, 32'h0, AXI_OKAY);
      rd(MODE_STATUS_OFFS, {27'h0, PRIO_LEVEL3, MODE_RUN}, AXI_OKAY);
      rd(8'h0C, 32'h0, AXI_SLVERR);
      wr(8'h0C, 32'h1, AXI_SLVERR);
      period(1'b0, n);
      cmp(n, 2);
      $display("test reset state done");
      for (i = 0; i < 4; i++) begin
         wr(MISC_CTRL1_OFFS, i * 2 + 1, AXI_OKAY);
         wait_mode(MODE_SLOW);
         period(1'b0, n);
         period(1'b0, n);
         cmp(n, 4 << i);
      end
      op(1'b1, 8'h00);
      tick(2);
      cmp(mode_out, MODE_SLOW_WAIT);
      period(1'b1, n);
      cmp(n, 32);
      irq(3'h1);
      wait_mode(MODE_SLOW);
      tick(3);
      rd(MODE_STATUS_OFFS, {27'h0, PRIO_LEVEL1, MODE_SLOW}, AXI_OKAY);
      irq_return_in <= 1'b1;
      tick(1);
      irq_return_in <= 1'b0;
      tick(1);
      rd(MODE_STATUS_OFFS, {27'h0, PRIO_LEVEL0, MODE_SLOW}, AXI_OKAY);
      wr(MISC_CTRL1_OFFS, 32'h0, AXI_OKAY);
      wait_mode(MODE_RUN);
      $display("test slow and slow-wait done");
      op(1'b1, 8'h00);
      tick(2);
      rd(MODE_STATUS_OFFS, {27'h0, PRIO_LEVEL0, MODE_WAIT}, AXI_OKAY);
      irq(3'h1);
      tick(2);
      cmp(mode_out, MODE_RUN);
      irq(3'h1);
      op(1'b0, HALT_OPCODE);
      tick(2);
      cmp(mode_out, MODE_RUN);
      op(1'b0, 8'h8F);
      tick(2);
      cmp(mode_out, MODE_RUN);
      $display("test wait and refused halt done");
      wr(CLK_CTRL_OFFS, 32'h1, AXI_OKAY);
      watchdog_enabled_in <= 1'b1;
      op(1'b0, HALT_OPCODE);
      tick(1);
      cmp(watchdog_reset_out, 1'b0);
      tick(1);
      cmp(mode_out, MODE_ACTIVE_HALT);
      rd(MODE_STATUS_OFFS, {27'h0, PRIO_LEVEL0, MODE_ACTIVE_HALT}, AXI_OKAY);
      irq(3'h4);
      tick(2);
      cmp(mode_out, MODE_RUN);
      wr(CLK_CTRL_OFFS, 32'h0, AXI_OKAY);
      op(1'b0, HALT_OPCODE);
      tick(1);
      cmp(watchdog_reset_out, 1'b1);
      tick(1);
      cmp(mode_out, MODE_HALT);
      cmp(osc_enable_out, 1'b0);
      irq(3'h2);
      wait_mode(MODE_OSC_STAB);
      for (n = 0; n < 50 && mode_out === MODE_OSC_STAB; n++) @(posedge core_clk_in);
      cmp(n, STAB);
      cmp(mode_out, MODE_RUN);
      $display("test halt modes done");
      test_done;
   end
endmodule // power_mode_controller_test
